//--- design/dpri_ctrl.sv
`timescale 1ns/1ps
`include "dpri_regs.svh"

// Function
// - Peripheral valid only with valid type
// - Ready high when request acceptable
// - Request codes single, burst, flush ack
// - Last flag used for single/burst only
// - Ack valid only with valid type
// - Ack codes single, burst, flush
// - Peripheral ack ready when able
// - Peripheral answers flush with flush ack unless its request is still valid
// - Interface present by build parameter
// - Event raises irq if enabled
// - Irq line held until clear
// - Abort raises abort interrupt
// - Abort irq follows faulting threads
// - Two APB ports, 32-bit
// - APB clock enable pulse
// - Active-low reset of whole block
// - Security state captured at reset release
module dpri_ctrl
#(
    parameter bit HAS_PERIPH = 1'b1
)
(
    input  wire logic                       sys_clk_in,
    input  wire logic                       srst_in,
    input  wire logic                       aresetn_in,
    dpri_if.ctrl                            prq,
    // Thread engine side
    input  wire logic                       xfer_done_in,
    input  wire logic                       xfer_burst_in,
    input  wire logic                       flush_req_in,
    input  wire logic                       req_consume_in,
    output logic                            req_pend_out,
    output dpri_pkg::dpri_type_t            req_type_out,
    output logic                            req_last_out,
    output logic                            flush_ack_out,
    // Events and aborts
    input  wire logic                       signal_event_instruction_in,
    input  wire logic [`DPRI_EVT_W-1:0]     event_num_in,
    input  wire logic [`DPRI_NUM_EVENTS-1:0] irq_enable_in,
    input  wire logic [`DPRI_NUM_EVENTS-1:0] irq_clear_in,
    input  wire logic                       abort_in,
    input  wire logic                       faulting_any_in,
    output logic [`DPRI_NUM_EVENTS-1:0]     irq_out,
    output logic                            irq_abort_out,
    // Security tie-off
    input  wire logic                       request_port_security_at_reset_in,
    output logic                            periph_ns_out,
    // Non-secure and secure APB ports
    input  wire logic                       pclken_in,
    input  wire logic                       psel_in,
    input  wire logic                       penable_in,
    input  wire logic                       pwrite_in,
    input  wire logic [`DPRI_APB_W-1:0]     paddr_in,
    input  wire logic [`DPRI_APB_W-1:0]     pwdata_in,
    output logic [`DPRI_APB_W-1:0]          prdata_out,
    output logic                            pready_out,
    input  wire logic                       spsel_in,
    input  wire logic                       spenable_in,
    input  wire logic                       spwrite_in,
    input  wire logic [`DPRI_APB_W-1:0]     spaddr_in,
    input  wire logic [`DPRI_APB_W-1:0]     spwdata_in,
    output logic [`DPRI_APB_W-1:0]          sprdata_out,
    output logic                            spready_out
);
    import dpri_pkg::*;

    logic       rst;
    logic       rst_d_r;
    dpri_rs_t   rs_r;
    logic       da_valid_r;
    dpri_type_t da_type_r;
    logic       flush_pend_r;
    logic       dr_fire;
    logic       da_fire;

    assign rst = srst_in | ~aresetn_in;

    assign dr_fire = prq.dr_valid & prq.dr_ready;
    assign da_fire = da_valid_r & prq.da_ready;

    // ------------------------------------------------------------
    // Request channel
    // ------------------------------------------------------------

    // ready reflects acceptability of presented type
    always_comb
    begin
        prq.dr_ready = 1'b0;
        if (HAS_PERIPH && !rst)
        begin
            unique case (rs_r)
                DPRI_RS_IDLE:  prq.dr_ready = (prq.dr_type == `DPRI_RQ_SINGLE) |
                                              (prq.dr_type == `DPRI_RQ_BURST);
                DPRI_RS_FLUSH: prq.dr_ready = (prq.dr_type == `DPRI_RQ_FLUSHACK);
                DPRI_RS_BUSY:  prq.dr_ready = 1'b0;
                default:       prq.dr_ready = 1'b0;
            endcase
        end
    end

    // Request state and captured request
    always_ff @(posedge sys_clk_in)
    begin
        if (rst)
        begin
            rs_r          <= DPRI_RS_IDLE;
            req_pend_out  <= 1'b0;
            req_type_out  <= `DPRI_RQ_SINGLE;
            req_last_out  <= 1'b0;
            flush_ack_out <= 1'b0;
        end
        else
        begin
            flush_ack_out <= 1'b0;
            if (dr_fire && rs_r == DPRI_RS_FLUSH)
            begin
                rs_r          <= DPRI_RS_IDLE;
                flush_ack_out <= 1'b1;
            end
            else if (dr_fire)
            begin
                rs_r         <= DPRI_RS_BUSY;
                req_pend_out <= 1'b1;
                req_type_out <= prq.dr_type;
                // last used only for single or burst
                req_last_out <= prq.dr_last;
            end
            else if (rs_r == DPRI_RS_BUSY && req_consume_in)
            begin
                rs_r         <= DPRI_RS_IDLE;
                req_pend_out <= 1'b0;
            end
            else if (rs_r == DPRI_RS_IDLE && flush_pend_r && da_fire)
            begin
                rs_r <= DPRI_RS_FLUSH;
            end
        end
    end

    // ------------------------------------------------------------
    // Acknowledge channel
    // ------------------------------------------------------------

    // valid held with type until taken
    always_ff @(posedge sys_clk_in)
    begin
        if (rst || !HAS_PERIPH)
        begin
            da_valid_r   <= 1'b0;
            da_type_r    <= `DPRI_AK_SINGLE;
            flush_pend_r <= 1'b0;
        end
        else if (da_fire)
        begin
            da_valid_r <= 1'b0;
        end
        else if (!da_valid_r)
        begin
            if (flush_req_in && rs_r == DPRI_RS_IDLE)
            begin
                da_valid_r   <= 1'b1;
                da_type_r    <= `DPRI_AK_FLUSH;
                flush_pend_r <= 1'b1;
            end
            else if (xfer_done_in)
            begin
                da_valid_r   <= 1'b1;
                da_type_r    <= xfer_burst_in ? `DPRI_AK_BURST : `DPRI_AK_SINGLE;
                flush_pend_r <= 1'b0;
            end
        end
    end

    assign prq.da_valid = da_valid_r;
    assign prq.da_type  = da_type_r;

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------

    // event sets enabled line; clear drops it, set wins
    always_ff @(posedge sys_clk_in)
    begin
        if (rst)
        begin
            irq_out <= '0;
        end
        else
        begin
            for (int i = 0; i < `DPRI_NUM_EVENTS; i++)
            begin
                if (signal_event_instruction_in && event_num_in == i[`DPRI_EVT_W-1:0] && irq_enable_in[i])
                    irq_out[i] <= 1'b1;
                else if (irq_clear_in[i])
                    irq_out[i] <= 1'b0;
            end
        end
    end

    // abort raises line; held while faulting
    always_ff @(posedge sys_clk_in)
    begin
        if (rst)
            irq_abort_out <= 1'b0;
        else
            irq_abort_out <= abort_in | faulting_any_in;
    end

    // capture security tie-off after reset release
    always_ff @(posedge sys_clk_in)
    begin
        rst_d_r <= rst;
        if (rst)
            periph_ns_out <= 1'b0;
        else if (rst_d_r)
            periph_ns_out <= request_port_security_at_reset_in;
    end

    // ------------------------------------------------------------
    // APB ports (register map lives elsewhere)
    // ------------------------------------------------------------

    // two ports; advance only on clock enable
    always_ff @(posedge sys_clk_in)
    begin
        if (rst)
        begin
            pready_out  <= 1'b0;
            spready_out <= 1'b0;
            prdata_out  <= '0;
            sprdata_out <= '0;
        end
        else if (pclken_in)
        begin
            pready_out  <= psel_in & ~penable_in;
            spready_out <= spsel_in & ~spenable_in;
            prdata_out  <= '0;
            sprdata_out <= '0;
        end
    end

endmodule : dpri_ctrl

//--- common/dpri_regs.svh
`ifndef DPRI_REGS_SVH
`define DPRI_REGS_SVH

// Request and acknowledge type codes
`define DPRI_RQ_SINGLE   2'h0
`define DPRI_RQ_BURST    2'h1
`define DPRI_RQ_FLUSHACK 2'h2
`define DPRI_AK_SINGLE   2'h0
`define DPRI_AK_BURST    2'h1
`define DPRI_AK_FLUSH    2'h2
`define DPRI_TYPE_W      2
`define DPRI_NUM_PERIPH  2
`define DPRI_NUM_EVENTS  4
`define DPRI_APB_W       32
`define DPRI_EVT_W       2

`endif

//--- common/dpri_pkg.sv
`include "dpri_regs.svh"

package dpri_pkg;

    // Type code carried on both channels
    typedef logic [`DPRI_TYPE_W-1:0] dpri_type_t;

    // Controller request channel state
    typedef enum logic [1:0]
    {
        DPRI_RS_IDLE  = 2'b00,
        DPRI_RS_BUSY  = 2'b01,
        DPRI_RS_FLUSH = 2'b10
    } dpri_rs_t;

endpackage : dpri_pkg

//--- common/dpri_if.sv
`timescale 1ns/1ps

interface dpri_if;
    import dpri_pkg::*;

    // Peripheral to controller request channel
    logic       dr_valid;
    logic       dr_ready;
    dpri_type_t dr_type;
    logic       dr_last;
    // Controller to peripheral acknowledge channel
    logic       da_valid;
    logic       da_ready;
    dpri_type_t da_type;

    modport ctrl
    (
        input  dr_valid, dr_type, dr_last, da_ready,
        output dr_ready, da_valid, da_type
    );

    modport periph
    (
        output dr_valid, dr_type, dr_last, da_ready,
        input  dr_ready, da_valid, da_type
    );

endinterface : dpri_if

//--- design/dpri_periph.sv
`timescale 1ns/1ps
`include "dpri_regs.svh"

module dpri_periph
(
    input  wire logic             sys_clk_in,
    input  wire logic             srst_in,
    dpri_if.periph                prq,
    // User side
    input  wire logic             user_req_in,
    input  wire logic             user_burst_in,
    input  wire logic             user_last_in,
    input  wire logic             user_ack_ready_in,
    output logic                  user_busy_out,
    output logic                  user_done_out,
    output dpri_pkg::dpri_type_t  user_done_type_out,
    output logic                  user_flushed_out
);
    import dpri_pkg::*;

    logic       dr_valid_r;
    dpri_type_t dr_type_r;
    logic       dr_last_r;
    logic       ack_fire;

    // acknowledge taken on valid and ready
    assign ack_fire     = prq.da_valid & prq.da_ready;
    assign prq.da_ready = user_ack_ready_in;

    // drive request, hold until taken, answer flush if no request is held
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            dr_valid_r <= 1'b0;
            dr_type_r  <= `DPRI_RQ_SINGLE;
            dr_last_r  <= 1'b0;
        end
        else if (dr_valid_r && prq.dr_ready)
        begin
            dr_valid_r <= 1'b0;
        end
        else if (!dr_valid_r && ack_fire && prq.da_type == `DPRI_AK_FLUSH)
        begin
            dr_valid_r <= 1'b1;
            dr_type_r  <= `DPRI_RQ_FLUSHACK;
            dr_last_r  <= 1'b0;
        end
        else if (!dr_valid_r && user_req_in)
        begin
            dr_valid_r <= 1'b1;
            dr_type_r  <= user_burst_in ? `DPRI_RQ_BURST : `DPRI_RQ_SINGLE;
            dr_last_r  <= user_last_in;
        end
    end

    assign prq.dr_valid = dr_valid_r;
    assign prq.dr_type  = dr_type_r;
    assign prq.dr_last  = dr_last_r;

    // User status: busy from request valid, done and flushed from acknowledge channel
    always_ff @(posedge sys_clk_in)
    begin
        if (srst_in)
        begin
            user_busy_out      <= 1'b0;
            user_done_out      <= 1'b0;
            user_done_type_out <= `DPRI_AK_SINGLE;
            user_flushed_out   <= 1'b0;
        end
        else
        begin
            user_busy_out    <= dr_valid_r;
            user_done_out    <= ack_fire && prq.da_type != `DPRI_AK_FLUSH;
            user_flushed_out <= ack_fire && prq.da_type == `DPRI_AK_FLUSH;
            if (ack_fire)
                user_done_type_out <= prq.da_type;
        end
    end

endmodule : dpri_periph

//--- dv/dpri_assertions.sv
`timescale 1ns/1ps

// ----------------------------------------
// Handshake checks on the request link
// ----------------------------------------
module dpri_assertions
(
    input  wire logic                 sys_clk_in,
    input  wire logic                 srst_in,
    input  wire logic                 dr_valid,
    input  wire logic                 dr_ready,
    input  wire dpri_pkg::dpri_type_t dr_type,
    input  wire logic                 dr_last,
    input  wire logic                 da_valid,
    input  wire logic                 da_ready,
    input  wire dpri_pkg::dpri_type_t da_type
);
    import dpri_pkg::*;

    // Common clock and reset
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    // Flush issued, then answered
    sequence s_flush_out;
        da_valid && da_ready && da_type == 2'h2;
    endsequence
    sequence s_flush_back;
        dr_valid && dr_ready && dr_type == 2'h2;
    endsequence

    a_req_code_refused: assert property (dr_valid && dr_type == 2'h3 |-> !dr_ready)
        else $error("reserved request code accepted");
    a_ack_code_legal: assert property (da_valid |-> da_type != 2'h3)
        else $error("reserved ack code driven");
    a_ack_held: assert property (da_valid && !da_ready |=> da_valid && $stable(da_type))
        else $error("ack dropped before handshake");
    a_req_held: assert property (dr_valid && !dr_ready |=> dr_valid && $stable(dr_type) && $stable(dr_last))
        else $error("request dropped before handshake");
    a_req_one_open: assert property (dr_valid && dr_ready && dr_type != 2'h2 |=> !dr_ready)
        else $error("second request accepted while busy");
    a_flush_answer: assert property (s_flush_out |-> ##[1:4] s_flush_back)
        else $error("flush not acknowledged");
    a_flush_only_ack: assert property (s_flush_out |=> !(dr_valid && dr_ready && dr_type != 2'h2) until s_flush_back)
        else $error("data request taken during flush");
    a_reset_quiet: assert property ($fell(srst_in) |-> !da_valid && !dr_valid)
        else $error("outputs active after reset");
endmodule : dpri_assertions

//--- dv/dma_periph_request_and_irq_tb_top.sv
`timescale 1ns/1ps

module dma_periph_request_and_irq_tb_top;
    import dpri_pkg::*;

    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic sys_clk_in = 1'b0, srst_in = 1'b1, aresetn_in, xfer_done_in, xfer_burst_in, flush_req_in, req_consume_in;
    logic signal_event_instruction_in, abort_in, faulting_any_in, request_port_security_at_reset_in, pclken_in;
    logic psel_in, penable_in, pwrite_in, spsel_in, spenable_in, spwrite_in;
    logic user_req_in, user_burst_in, user_last_in, user_ack_ready_in;
    logic [1:0]  event_num_in;
    logic [3:0]  irq_enable_in, irq_clear_in, irq_out;
    logic [31:0] paddr_in, pwdata_in, spaddr_in, spwdata_in, prdata_out, sprdata_out;
    logic req_pend_out, req_last_out, flush_ack_out, irq_abort_out, periph_ns_out, pready_out, spready_out;
    logic user_busy_out, user_done_out, user_flushed_out;
    dpri_type_t req_type_out, user_done_type_out;
    int fail_count = 0;
    int tests_run  = 0;

    // Clock
    always #50 sys_clk_in = ~sys_clk_in;

    // Both ends joined by one link
    dpri_if bus ();
    dpri_ctrl i_dpri_ctrl (.sys_clk_in, .srst_in, .aresetn_in, .prq(bus.ctrl), .xfer_done_in, .xfer_burst_in,
        .flush_req_in, .req_consume_in, .req_pend_out, .req_type_out, .req_last_out, .flush_ack_out,
        .signal_event_instruction_in, .event_num_in, .irq_enable_in, .irq_clear_in, .abort_in,
        .faulting_any_in, .irq_out, .irq_abort_out, .request_port_security_at_reset_in, .periph_ns_out,
        .pclken_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
        .spsel_in, .spenable_in, .spwrite_in, .spaddr_in, .spwdata_in, .sprdata_out, .spready_out);
    dpri_periph i_dpri_periph (.sys_clk_in, .srst_in, .prq(bus.periph), .user_req_in, .user_burst_in,
        .user_last_in, .user_ack_ready_in, .user_busy_out, .user_done_out, .user_done_type_out, .user_flushed_out);
    dpri_assertions i_dpri_assertions (.sys_clk_in, .srst_in, .dr_valid(bus.dr_valid), .dr_ready(bus.dr_ready),
        .dr_type(bus.dr_type), .dr_last(bus.dr_last), .da_valid(bus.da_valid), .da_ready(bus.da_ready),
        .da_type(bus.da_type));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task step;
        @(posedge sys_clk_in);
        #1;
    endtask : step

    task chk(input logic c, input string m);
        tests_run++;
        if (c !== 1'b1)
        begin
            fail_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask : chk

    task print_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    task automatic wt(ref logic s);
        for (int i = 0; i < 20 && s !== 1'b1; i++)
            step();
        chk(s, "wait bound used up");
        if (s !== 1'b1)
            print_verdict();
    endtask : wt

    task rst;
        srst_in = 1'b1;
        repeat (3) step();
        srst_in = 1'b0;
        step();
    endtask : rst

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_req(input logic b);
        user_burst_in = b;
        user_last_in = ~b;
        user_req_in = 1'b1;
        wt(req_pend_out);
        user_req_in = 1'b0;
        chk(req_type_out === {1'b0, b} && req_last_out === ~b, "request type or last");
        chk(user_busy_out === 1'b1, "request not shown as pending");
        req_consume_in = 1'b1;
        step();
        req_consume_in = 1'b0;
        step();
        chk(req_pend_out === 1'b0 && user_busy_out === 1'b0, "request not released");
    endtask : t_req

    task t_ack(input logic b);
        xfer_burst_in = b;
        user_ack_ready_in = 1'b0;
        xfer_done_in = 1'b1;
        step();
        xfer_done_in = 1'b0;
        repeat (3) step();
        chk(bus.da_valid === 1'b1 && bus.da_type === {1'b0, b}, "ack not held");
        user_ack_ready_in = 1'b1;
        wt(user_done_out);
        chk(user_done_type_out === {1'b0, b}, "ack type");
    endtask : t_ack

    task t_flush;
        user_last_in = 1'b1;
        flush_req_in = 1'b1;
        step();
        flush_req_in = 1'b0;
        chk(bus.da_valid === 1'b1 && bus.da_type === 2'h2, "flush request not shown");
        step();
        chk(user_flushed_out === 1'b1, "flush not taken by peripheral");
        wt(flush_ack_out);
        step();
        chk(req_pend_out === 1'b0, "flush ack taken as data");
    endtask : t_flush

    task t_irq;
        irq_enable_in = 4'h5;
        for (int e = 0; e < 4; e++)
        begin
            event_num_in = e[1:0];
            signal_event_instruction_in = 1'b1;
            step();
            signal_event_instruction_in = 1'b0;
            step();
        end
        chk(irq_out === 4'h5, "event lines");
        irq_clear_in = 4'h1;
        step();
        irq_clear_in = 4'h0;
        step();
        chk(irq_out === 4'h4, "event clear");
        event_num_in = 2'h2;
        signal_event_instruction_in = 1'b1;
        irq_clear_in = 4'h4;
        step();
        {signal_event_instruction_in, irq_clear_in} = 5'h00;
        chk(irq_out === 4'h4, "clear beat event");
    endtask : t_irq

    task t_abort;
        abort_in = 1'b1;
        step();
        abort_in = 1'b0;
        chk(irq_abort_out === 1'b1, "abort");
        faulting_any_in = 1'b1;
        repeat (3) step();
        chk(irq_abort_out === 1'b1, "faulting");
        faulting_any_in = 1'b0;
        repeat (2) step();
        chk(irq_abort_out === 1'b0, "abort stuck");
    endtask : t_abort

    task t_sec;
        request_port_security_at_reset_in = 1'b1;
        aresetn_in = 1'b0;
        step();
        aresetn_in = 1'b1;
        repeat (2) step();
        chk(periph_ns_out === 1'b1 && irq_out === 4'h0, "low reset");
        request_port_security_at_reset_in = 1'b0;
        rst();
        step();
        chk(periph_ns_out === 1'b0, "secure state");
        request_port_security_at_reset_in = 1'b1;
        step();
        chk(periph_ns_out === 1'b0, "tie-off taken after reset");
    endtask : t_sec

    task t_apb(input logic s);
        {paddr_in, spaddr_in} = {2{32'h0000_0010}};
        {pwdata_in, spwdata_in} = {2{32'hA5A5_0001}};
        {pwrite_in, spwrite_in} = 2'h3;
        {spsel_in, psel_in} = {s, ~s};
        pclken_in = 1'b0;
        step();
        chk({spready_out, pready_out} === 2'h0, "apb moved without enable");
        pclken_in = 1'b1;
        step();
        {spenable_in, penable_in} = {s, ~s};
        for (int i = 0; i < 8 && (s ? spready_out : pready_out) !== 1'b1; i++)
            step();
        chk((s ? spready_out : pready_out) === 1'b1 && (s ? sprdata_out : prdata_out) === 32'h0, "apb access");
        step();
        {spsel_in, psel_in, spenable_in, penable_in} = 4'h0;
        step();
    endtask : t_apb

    // Main sequence
    initial
    begin
        {aresetn_in, xfer_done_in, xfer_burst_in, flush_req_in, req_consume_in, abort_in} = 6'h20;
        {signal_event_instruction_in, faulting_any_in, request_port_security_at_reset_in} = 3'h0;
        {pclken_in, psel_in, penable_in, pwrite_in, spsel_in, spenable_in, spwrite_in} = 7'h40;
        {user_req_in, user_burst_in, user_last_in, user_ack_ready_in, event_num_in} = 6'h0;
        {irq_enable_in, irq_clear_in, paddr_in, pwdata_in, spaddr_in, spwdata_in} = '0;
        rst();
        t_req(1'b0);
        t_req(1'b1);
        t_ack(1'b0);
        t_ack(1'b1);
        t_flush();
        t_irq();
        t_abort();
        t_sec();
        t_apb(1'b0);
        t_apb(1'b1);
        print_verdict();
    end
endmodule : dma_periph_request_and_irq_tb_top
